// >>> src/vfd_command_ram_writer.sv
// Purpose: Serial command interpreter and display RAMs of a 16-digit dot display
// Assumes: Host keeps link timing; fixed pattern ROM sits outside on romCode
// Notes: Grid, segment and symbol outputs blank while the grid window is off
module vfd_command_ram_writer
  import vfd_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic resetN,
  input wire logic chipSelectN,
  input wire logic shiftClockN,
  input wire logic serialDataIn,
  input wire logic [PAT_BITS-1:0] romPattern,
  output logic [7:0] romCode,
  output logic [DIGITS-1:0] gridOutput,
  output logic [PAT_BITS-1:0] segmentOutput,
  output logic [1:0] symbolOutput,
  output logic portLineA,
  output logic portLineB
);
  rx_byte_t rxByte;
  logic rxValid;
  scan_t scan;
  scan_t stage;
  mode_t mode;
  logic [1:0] resetSync;
  logic [7:0] duty;
  logic [3:0] digitCount;
  logic [3:0] charAddr;
  logic [2:0] patAddr;
  logic [3:0] symAddr;
  logic [2:0] patByte;
  logic [PAT_BITS-1:0] patBuf;
  logic [1:0] symbolNow;
  logic [7:0] charRam [DIGITS];
  logic [PAT_BITS-1:0] patRam [PATTERNS];
  logic [1:0] symRam [DIGITS];
  logic charWe;
  logic patByteWe;
  logic symWe;
  logic dutyWe;

  serial_byte_rx u_rx (
    .clk(clk),
    .sys_rst(sys_rst),
    .chipSelectN(chipSelectN),
    .shiftClockN(shiftClockN),
    .serialDataIn(serialDataIn),
    .rxByte(rxByte),
    .rxValid(rxValid)
  );

  grid_scan u_scan (
    .clk(clk),
    .sys_rst(sys_rst),
    .duty(duty),
    .digitCount(digitCount),
    .scan(scan)
  );

  // Reset pin is asynchronous to clk
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      resetSync <= 2'h3;
    end else begin
      resetSync <= {resetSync[0], ~resetN};
    end
  end

  wire pinReset = resetSync[1];

  wire contPat = (mode == MODE_PAT) && (patByte != PAT_BYTE_FIRST);
  wire isCmd = rxValid && rxByte.first && !contPat;
  wire isData = rxValid && !isCmd;
  wire [3:0] op = rxByte.data[7:4];

  wire cmdChar = isCmd && (op == OP_CHAR);
  wire cmdPat = isCmd && (op == OP_PAT);
  wire cmdSym = isCmd && (op == OP_SYM);
  wire cmdPort = isCmd && (op == OP_PORT);
  wire cmdDuty = isCmd && (op == OP_DUTY);
  wire cmdDigits = isCmd && (op == OP_DIGITS);
  wire cmdKnown = cmdChar | cmdPat | cmdSym | cmdPort | cmdDuty | cmdDigits;

  // Data bytes go where the last command pointed
  always_comb begin
    charWe = 1'b0;
    patByteWe = 1'b0;
    symWe = 1'b0;
    dutyWe = 1'b0;
    unique case (mode)
      MODE_IDLE: begin
      end
      MODE_CHAR: begin
        charWe = isData;
      end
      MODE_PAT: begin
        patByteWe = isData;
      end
      MODE_SYM: begin
        symWe = isData;
      end
      MODE_DUTY: begin
        dutyWe = isData;
      end
    endcase
  end

  wire patWe = patByteWe && (patByte == PAT_BYTE_LAST);

  // unknown opcodes only drop the mode
  wire mode_t next_mode = cmdChar ? MODE_CHAR :
                          cmdPat ? MODE_PAT :
                          cmdSym ? MODE_SYM :
                          cmdDuty ? MODE_DUTY :
                          (isCmd || dutyWe) ? MODE_IDLE : mode;

  wire [3:0] next_charAddr = cmdChar ? rxByte.data[3:0] :
                             charWe ? 4'(charAddr + 4'h1) : charAddr;
  wire [2:0] next_patAddr = cmdPat ? rxByte.data[2:0] :
                            patWe ? 3'(patAddr + 3'h1) : patAddr;
  wire [3:0] next_symAddr = cmdSym ? rxByte.data[3:0] :
                            symWe ? 4'(symAddr + 4'h1) : symAddr;
  wire [2:0] next_patByte = (cmdPat || patWe) ? PAT_BYTE_FIRST :
                            patByteWe ? 3'(patByte + 3'h1) : patByte;
  wire [7:0] next_duty = dutyWe ? rxByte.data : duty;
  wire [3:0] next_digitCount = cmdDigits ? rxByte.data[3:0] : digitCount;
  // port lines from bits 0 and 1
  wire next_portLineA = cmdPort ? rxByte.data[0] : portLineA;
  wire next_portLineB = cmdPort ? rxByte.data[1] : portLineB;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode <= MODE_IDLE;
      charAddr <= ADDR_RESET;
      patAddr <= PAT_ADDR_RESET;
      symAddr <= ADDR_RESET;
      patByte <= PAT_BYTE_FIRST;
    end else if (pinReset) begin
      mode <= MODE_IDLE;
      charAddr <= ADDR_RESET;
      patAddr <= PAT_ADDR_RESET;
      symAddr <= ADDR_RESET;
      patByte <= PAT_BYTE_FIRST;
    end else begin
      mode <= next_mode;
      charAddr <= next_charAddr;
      patAddr <= next_patAddr;
      symAddr <= next_symAddr;
      patByte <= next_patByte;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      duty <= DUTY_RESET;
      digitCount <= DIGITS_ALL;
      portLineA <= PORT_RESET[0];
      portLineB <= PORT_RESET[1];
    end else if (pinReset) begin
      duty <= DUTY_RESET;
      digitCount <= DIGITS_ALL;
      portLineA <= PORT_RESET[0];
      portLineB <= PORT_RESET[1];
    end else begin
      duty <= next_duty;
      digitCount <= next_digitCount;
      portLineA <= next_portLineA;
      portLineB <= next_portLineB;
    end
  end

  // byte k fills bits k, k+5 .. k+30
  logic [PAT_BITS-1:0] patMerged;
  for (genvar k = 0; k < PAT_BYTES; k++) begin : g_patCol
    for (genvar j = 0; j < PAT_ROWS; j++) begin : g_patRow
      assign patMerged[k + PAT_BYTES * j] =
        (patByte == 3'(k)) ? rxByte.data[j] : patBuf[k + PAT_BYTES * j];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      patBuf <= '0;
    end else if (patByteWe) begin
      patBuf <= patMerged;
    end
  end

  // Contents survive the reset pin; cleared only on sys_rst
  for (genvar i = 0; i < DIGITS; i++) begin : g_digitRam
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        charRam[i] <= 8'h00;
        symRam[i] <= 2'h0;
      end else begin
        if (charWe && (charAddr == 4'(i))) begin
          charRam[i] <= rxByte.data;
        end
        if (symWe && (symAddr == 4'(i))) begin
          symRam[i] <= rxByte.data[1:0];
        end
      end
    end
  end

  for (genvar p = 0; p < PATTERNS; p++) begin : g_patRam
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        patRam[p] <= '0;
      end else if (patWe && (patAddr == 3'(p))) begin
        patRam[p] <= patMerged;
      end
    end
  end

  // First display stage: fetch code and symbols of the scanned digit
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      romCode <= 8'h00;
      symbolNow <= 2'h0;
      stage <= '0;
    end else begin
      romCode <= charRam[scan.digit];
      symbolNow <= symRam[scan.digit];
      stage <= scan;
    end
  end

  // user codes 00..07 bypass the ROM
  wire userCode = (romCode <= USER_CODE_TOP);
  wire [PAT_BITS-1:0] userSel = patRam[romCode[2:0]];
  wire [PAT_BITS-1:0] next_segment = stage.on ? (userCode ? userSel : romPattern) : '0;
  wire [DIGITS-1:0] next_grid = stage.on ? DIGITS'(GRID_ONE << stage.digit) : '0;
  wire [1:0] next_symbol = stage.on ? symbolNow : 2'h0;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      segmentOutput <= '0;
      gridOutput <= '0;
      symbolOutput <= 2'h0;
    end else begin
      segmentOutput <= next_segment;
      gridOutput <= next_grid;
      symbolOutput <= next_symbol;
    end
  end

  a_port_update: assert property (
    @(posedge clk) disable iff (sys_rst)
    cmdPort && !pinReset |=> {portLineB, portLineA} == $past(rxByte.data[1:0]))
    else $error("port lines do not follow command bits");

  a_char_wrap: assert property (
    @(posedge clk) disable iff (sys_rst)
    charWe && !pinReset |=> charAddr == 4'($past(charAddr) + 4'h1))
    else $error("character address did not advance");

  a_sym_advance: assert property (
    @(posedge clk) disable iff (sys_rst)
    symWe && !pinReset ##1 1 |-> symAddr == 4'($past(symAddr) + 4'h1))
    else $error("symbol address did not advance");

  a_pat_advance: assert property (
    @(posedge clk) disable iff (sys_rst)
    patWe && !pinReset |=> patAddr == 3'($past(patAddr) + 3'h1) && patByte == PAT_BYTE_FIRST)
    else $error("pattern address did not advance");

  a_duty_write: assert property (
    @(posedge clk) disable iff (sys_rst)
    dutyWe && !pinReset |=> duty == $past(rxByte.data) && mode == MODE_IDLE)
    else $error("duty byte not taken");

  a_unknown_ignored: assert property (
    @(posedge clk) disable iff (sys_rst)
    isCmd && !cmdKnown && !pinReset |=> $stable(duty) && $stable(digitCount)
      && $stable(portLineA) && $stable(portLineB) && $stable(charAddr) && mode == MODE_IDLE)
    else $error("undefined command changed state");

  a_reset_values: assert property (
    @(posedge clk) disable iff (sys_rst)
    pinReset |=> duty == DUTY_RESET && digitCount == DIGITS_ALL && charAddr == ADDR_RESET
      && symAddr == ADDR_RESET && patAddr == PAT_ADDR_RESET && !portLineA && !portLineB)
    else $error("reset did not restore settings");

  a_duty_window: assert property (
    @(posedge clk) disable iff (sys_rst)
    ##1 scan.on == (scan.step < (($past(duty) > DUTY_CAP) ? DUTY_CAP : $past(duty))))
    else $error("grid window does not match duty");

  a_digit_range: assert property (
    @(posedge clk) disable iff (sys_rst)
    $changed(scan.digit) |-> scan.digit == ADDR_RESET || $past(digitCount, 2) == DIGITS_ALL
      || scan.digit < $past(digitCount, 2))
    else $error("scan passed the digit count");

  a_user_select: assert property (
    @(posedge clk) disable iff (sys_rst)
    stage.on && userCode |=> segmentOutput == $past(userSel))
    else $error("user code not taken from pattern RAM");

  a_rom_select: assert property (
    @(posedge clk) disable iff (sys_rst)
    stage.on && !userCode |=> segmentOutput == $past(romPattern))
    else $error("high code not taken from fixed ROM");

  a_grid_onehot: assert property (
    @(posedge clk) disable iff (sys_rst)
    stage.on |=> gridOutput == DIGITS'(GRID_ONE << $past(stage.digit))
      && symbolOutput == $past(symbolNow))
    else $error("wrong grid or symbol output");

  c_char_write: cover property (@(posedge clk) disable iff (sys_rst) cmdChar ##[1:400] charWe);
  c_pattern_done: cover property (@(posedge clk) disable iff (sys_rst) patWe);
  c_duty_set: cover property (@(posedge clk) disable iff (sys_rst) cmdDuty ##[1:400] dutyWe);
  c_digits_set: cover property (@(posedge clk) disable iff (sys_rst) cmdDigits);
endmodule : vfd_command_ram_writer

// >>> src/vfd_pkg.sv
// Purpose: Shared constants and types of the display command interpreter
// Assumes: 40 MHz system clock, LSB-first serial bytes from the host
// Notes: Opcodes are the upper nibble of a first byte read as B7..B4
package vfd_pkg;
  localparam int DIGITS = 16;
  localparam int PATTERNS = 8;
  localparam int PAT_BITS = 35;
  localparam int PAT_BYTES = 5;
  localparam int PAT_ROWS = 7;
  localparam logic [3:0] OP_CHAR = 4'h1;
  localparam logic [3:0] OP_PAT = 4'h2;
  localparam logic [3:0] OP_SYM = 4'h3;
  localparam logic [3:0] OP_PORT = 4'h4;
  localparam logic [3:0] OP_DUTY = 4'h5;
  localparam logic [3:0] OP_DIGITS = 4'h6;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] SYNC_IDLE = 3'h7;
  localparam logic [7:0] DUTY_CAP = 8'hF0;
  localparam logic [7:0] STEP_LAST = 8'hFF;
  localparam logic [7:0] DUTY_RESET = 8'h00;
  localparam logic [3:0] DIGITS_ALL = 4'h0;
  localparam logic [3:0] DIGIT_MAX = 4'hF;
  localparam logic [1:0] PORT_RESET = 2'h0;
  localparam logic [3:0] ADDR_RESET = 4'h0;
  localparam logic [2:0] PAT_ADDR_RESET = 3'h0;
  localparam logic [2:0] PAT_BYTE_FIRST = 3'h0;
  localparam logic [2:0] PAT_BYTE_LAST = 3'h4;
  localparam logic [7:0] USER_CODE_TOP = 8'h07;
  localparam logic [15:0] GRID_ONE = 16'h0001;
  localparam int CLK_PERIOD_NS = 25;
  localparam int SELECT_HIGH_GAP_NS = 300;
  localparam int SELECT_HIGH_GAP_CYC =
    (SELECT_HIGH_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [4:0] {
    MODE_IDLE = 5'h01,
    MODE_CHAR = 5'h02,
    MODE_PAT = 5'h04,
    MODE_SYM = 5'h08,
    MODE_DUTY = 5'h10
  } mode_t;

  typedef struct packed {
    logic first;
    logic [7:0] data;
  } rx_byte_t;

  typedef struct packed {
    logic [3:0] digit;
    logic [7:0] step;
    logic on;
  } scan_t;
endpackage : vfd_pkg

// >>> src/serial_byte_rx.sv
// Purpose: Samples the three-wire link and delivers whole bytes
// Assumes: Link pins are asynchronous to clk and slow against it
// Notes: Byte count restarts whenever chip select is high
module serial_byte_rx
  import vfd_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic chipSelectN,
  input wire logic shiftClockN,
  input wire logic serialDataIn,
  output rx_byte_t rxByte,
  output logic rxValid
);
  logic [2:0] selSync;
  logic [2:0] clkSync;
  logic [1:0] dataSync;
  logic [2:0] bitCount;
  logic [7:0] shiftReg;
  logic firstPend;

  wire active = ~selSync[1];
  wire riseEdge = active & clkSync[1] & ~clkSync[2];
  wire [7:0] shifted = {dataSync[1], shiftReg[7:1]};
  wire byteDone = riseEdge && (bitCount == BIT_LAST);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      selSync <= SYNC_IDLE;
      clkSync <= SYNC_IDLE;
      dataSync <= 2'h0;
    end else begin
      selSync <= {selSync[1:0], chipSelectN};
      clkSync <= {clkSync[1:0], shiftClockN};
      dataSync <= {dataSync[0], serialDataIn};
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bitCount <= 3'h0;
      shiftReg <= 8'h00;
      firstPend <= 1'b1;
    end else if (!active) begin
      bitCount <= 3'h0;
      firstPend <= 1'b1;
    end else if (riseEdge) begin
      shiftReg <= shifted;
      bitCount <= 3'(bitCount + 3'h1);
      firstPend <= firstPend & ~byteDone;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxValid <= 1'b0;
      rxByte <= '0;
    end else begin
      rxValid <= byteDone;
      if (byteDone) begin
        rxByte <= '{first: firstPend, data: shifted};
      end
    end
  end
endmodule : serial_byte_rx

// >>> src/grid_scan.sv
// Purpose: Steps through digit slots and times the grid on-window
// Assumes: One slot step per clk cycle
// Notes: A shortened digit count takes effect at the next slot end
module grid_scan
  import vfd_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] duty,
  input wire logic [3:0] digitCount,
  output scan_t scan
);
  logic [7:0] step;
  logic [3:0] digit;

  wire [7:0] onSteps = (duty > DUTY_CAP) ? DUTY_CAP : duty;
  wire [3:0] lastDigit = (digitCount == DIGITS_ALL) ? DIGIT_MAX : 4'(digitCount - 4'h1);
  wire slotEnd = (step == STEP_LAST);
  wire [3:0] next_digit = (digit >= lastDigit) ? ADDR_RESET : 4'(digit + 4'h1);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      step <= 8'h00;
      digit <= ADDR_RESET;
    end else begin
      step <= 8'(step + 8'h01);
      if (slotEnd) begin
        digit <= next_digit;
      end
    end
  end

  // grid on for first duty steps, capped at DUTY_CAP
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scan <= '0;
    end else begin
      scan <= '{digit: digit, step: step, on: (step < onSteps)};
    end
  end
endmodule : grid_scan

// >>> testbench/host_link_model.sv
// Purpose: Host side of the three-wire link, sends whole frames
// Assumes: 200 ns shift clock period, eight clk cycles per bit
// Notes: Data line shows the inverse of its last bit while deselected
module host_link_model
  import vfd_pkg::*;
(
  input wire logic clk,
  output logic chipSelectN,
  output logic shiftClockN,
  output logic serialDataIn
);
  timeunit 1ns;
  timeprecision 100ps;
  // Opening tick of the next frame completes the select-high gap
  localparam int GAP_CYC = SELECT_HIGH_GAP_CYC - 1;

  initial begin
    chipSelectN = 1'b1;
    shiftClockN = 1'b1;
    serialDataIn = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick

  task automatic sendFrame(input logic [63:0] bytes, input int n);
    tick(1);
    chipSelectN = 1'b0;
    tick(2);
    for (int i = 0; i < 8 * n; i++) begin
      shiftClockN = 1'b0;
      serialDataIn = bytes[i];
      tick(4);
      shiftClockN = 1'b1;
      tick(4);
    end
    chipSelectN = 1'b1;
    serialDataIn = ~serialDataIn;
    tick(GAP_CYC);
  endtask : sendFrame
endmodule : host_link_model

// >>> testbench/tb_vfd_command_ram_writer.sv
// Purpose: Self-checking bench of the display command interpreter
// Assumes: Host model drives the link; fixed ROM modelled from the code
// Notes: Display results are read off the scanned grid window
module tb_vfd_command_ram_writer
  import vfd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [34:0] PAT_A = 35'h5_A5C3_9E17;
  localparam logic [34:0] PAT_B = 35'h2_1F0F_6A99;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic resetN = 1'b1;
  logic chipSelectN;
  logic shiftClockN;
  logic serialDataIn;
  logic [PAT_BITS-1:0] romPattern;
  logic [7:0] romCode;
  logic [DIGITS-1:0] gridOutput;
  logic [PAT_BITS-1:0] segmentOutput;
  logic [1:0] symbolOutput;
  logic portLineA;
  logic portLineB;
  logic [15:0] seen;
  logic [39:0] patA;
  logic [39:0] patB;
  logic [7:0] junk [4] = '{8'h83, 8'hF2, 8'h02, 8'h71};
  logic [7:0] dutyIn [4] = '{8'h01, 8'hFF, 8'hF0, 8'hEF};
  int dutyOn [4] = '{1, 240, 240, 239};
  logic [3:0] cnt [4] = '{4'h1, 4'hF, 4'h3, 4'h0};
  logic [15:0] cntMask [4] = '{16'h0001, 16'h7FFF, 16'h0007, 16'hFFFF};
  int n_fail = 0;
  int samples_checked = 0;

  function automatic logic [34:0] romOf(input logic [7:0] code);
    return {code[2:0], {4{code}}};
  endfunction : romOf

  // Byte k holds bits k, k+5 .. k+30; bit 7 set as noise
  function automatic logic [39:0] packPat(input logic [34:0] p);
    logic [39:0] f;
    f = '1;
    for (int k = 0; k < 5; k++)
      for (int j = 0; j < 7; j++)
        f[8*k+j] = p[k+5*j];
    return f;
  endfunction : packPat

  always #12.5 clk = ~clk;
  // Fixed pattern ROM stand-in
  assign romPattern = romOf(romCode);

  vfd_command_ram_writer dut (
    .clk(clk),
    .sys_rst(sys_rst),
    .resetN(resetN),
    .chipSelectN(chipSelectN),
    .shiftClockN(shiftClockN),
    .serialDataIn(serialDataIn),
    .romPattern(romPattern),
    .romCode(romCode),
    .gridOutput(gridOutput),
    .segmentOutput(segmentOutput),
    .symbolOutput(symbolOutput),
    .portLineA(portLineA),
    .portLineB(portLineB)
  );

  host_link_model host (
    .clk(clk),
    .chipSelectN(chipSelectN),
    .shiftClockN(shiftClockN),
    .serialDataIn(serialDataIn)
  );

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick

  task automatic wrap_up;
    if (n_fail == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  task automatic checkVal(input logic [34:0] got, input logic [34:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %0h, expected %0h", $time, got, exp);
    end
  endtask : checkVal

  task automatic checkCount(input int got, input int exp);
    samples_checked++;
    if (got != exp) begin
      n_fail++;
      $display("unexpected at %0t: got %0h, expected %0h", $time, got, exp);
    end
  endtask : checkCount

  task automatic send(input logic [63:0] bytes, input int n);
    host.sendFrame(bytes, n);
    tick(10);
  endtask : send

  task automatic waitGrid(input int d);
    for (int i = 0; i < 5000; i++) begin
      tick(1);
      if (gridOutput === (GRID_ONE << d))
        return;
    end
    n_fail++;
    wrap_up();
  endtask : waitGrid

  task automatic checkDigit(input int d, input logic [34:0] segment_output, input logic [1:0] sym);
    waitGrid(d);
    checkVal(segmentOutput, segment_output);
    checkVal({33'h0, symbolOutput}, {33'h0, sym});
  endtask : checkDigit

  // Start on digit one so the digit zero window is seen whole
  task automatic onTime(input int exp);
    int n;
    n = 0;
    waitGrid(1);
    waitGrid(0);
    while (gridOutput[0] === 1'b1 && n < 300) begin
      n++;
      tick(1);
    end
    checkCount(n, exp);
  endtask : onTime

  task automatic scanMask;
    tick(512);
    seen = '0;
    repeat (DIGITS * 256) begin
      tick(1);
      seen |= gridOutput;
    end
  endtask : scanMask

  initial begin
    repeat (3) @(posedge clk);
    #2;
    sys_rst = 1'b0;
    tick(4);
    checkVal({33'h0, portLineB, portLineA}, 35'h0);
    scanMask();
    checkVal({19'h0, seen}, 35'h0);
    for (int v = 3; v >= 0; v--) begin
      send(64'h4C | v, 1);
      checkVal({33'h0, portLineB, portLineA}, 35'(v));
    end
    send(64'h41, 1);
    foreach (junk[i]) begin
      send({56'h0, junk[i]}, 1);
      checkVal({33'h0, portLineB, portLineA}, 35'h1);
    end
    send(64'h2050, 2);
    send(64'h02_85_03_41_1E, 5);
    patA = packPat(PAT_A);
    patB = packPat(PAT_B);
    host.sendFrame({patB[15:0], patA, 8'h22}, 8);
    send({40'h0, patB[39:16]}, 3);
    send(64'hFC_03_FE_FD_3E, 5);
    checkDigit(14, romOf(8'h41), 2'h1);
    checkDigit(15, PAT_B, 2'h2);
    checkDigit(0, romOf(8'h85), 2'h3);
    checkDigit(1, PAT_A, 2'h0);
    foreach (dutyIn[i]) begin
      send({48'h0, dutyIn[i], 8'h50}, 2);
      onTime(dutyOn[i]);
    end
    send(64'h2050, 2);
    foreach (cnt[i]) begin
      send({56'h0, 4'h6, cnt[i]}, 1);
      scanMask();
      checkVal({19'h0, seen}, {19'h0, cntMask[i]});
    end
    send(64'h43, 1);
    resetN = 1'b0;
    tick(4);
    resetN = 1'b1;
    tick(4);
    checkVal({33'h0, portLineB, portLineA}, 35'h0);
    scanMask();
    checkVal({19'h0, seen}, 35'h0);
    wrap_up();
  end
endmodule : tb_vfd_command_ram_writer
